// *** hdl/mic_pkg.sv ***
// Package for the interrupt request and enable block.
// Assumes an APB bus with 32-bit data and byte addresses.
package mic_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFF_CMP = 8'h00;
  localparam logic [7:0] OFF_EDGE = 8'h04;
  localparam logic [7:0] OFF_CTRL_A = 8'h08;
  localparam logic [7:0] OFF_CTRL_B = 8'h0C;
  localparam logic [7:0] OFF_CTRL_C = 8'h10;
  localparam logic [7:0] OFF_GROUP_ZERO = 8'h14;
  localparam logic [7:0] OFF_GROUP_TWO = 8'h18;

  // Reset values; hysteresis is on after reset.
  localparam logic [7:0] CMP_RST = 8'h01;
  localparam logic [7:0] REG_RST = 8'h00;

  // Edge-select codes of each external pin.
  localparam logic [1:0] EDGE_OFF = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;

  // Vector codes; also the bit order of the primary request vector.
  localparam int NUM_VEC = 10;
  localparam logic [3:0] VEC_PIN_A = 4'h0;
  localparam logic [3:0] VEC_PIN_B = 4'h1;
  localparam logic [3:0] VEC_CONV = 4'h2;
  localparam logic [3:0] VEC_GROUP_ZERO = 4'h3;
  localparam logic [3:0] VEC_GROUP_TWO = 4'h4;
  localparam logic [3:0] VEC_SERIAL = 4'h5;
  localparam logic [3:0] VEC_TICK_A = 4'h6;
  localparam logic [3:0] VEC_TICK_B = 4'h7;
  localparam logic [3:0] VEC_TOUCH = 4'h8;
  localparam logic [3:0] VEC_CMP = 4'h9;

  // ----------------------------------------------------------------
  // Register layouts, bit 7 first; rsv fields always hold zero
  // ----------------------------------------------------------------
  typedef struct packed {
    logic rsv7;
    logic cmp_power_on;
    logic cmp_polarity_invert;
    logic cmp_result_bit;
    logic [2:0] rsv3_1;
    logic cmp_hysteresis_on;
  } mic_cmp_t;

  typedef struct packed {
    logic [3:0] rsv7_4;
    logic [1:0] pin_b_edge_sel;
    logic [1:0] pin_a_edge_sel;
  } mic_edge_t;

  typedef struct packed {
    logic rsv7;
    logic conv_done_flag;
    logic pin_b_flag;
    logic pin_a_flag;
    logic conv_done_enable;
    logic pin_b_enable;
    logic pin_a_enable;
    logic global_irq_enable;
  } mic_ctrl_a_t;

  typedef struct packed {
    logic serial_port_flag;
    logic group_two_flag;
    logic rsv5;
    logic group_zero_flag;
    logic serial_port_enable;
    logic group_two_enable;
    logic rsv1;
    logic group_zero_enable;
  } mic_ctrl_b_t;

  typedef struct packed {
    logic comparator_flag;
    logic touch_sense_flag;
    logic tick_b_flag;
    logic tick_a_flag;
    logic comparator_enable;
    logic touch_sense_enable;
    logic tick_b_enable;
    logic tick_a_enable;
  } mic_ctrl_c_t;

  // Group zero: hi = timer A match, lo = timer period match.
  // Group two: hi = eeprom done, lo = low supply.
  typedef struct packed {
    logic [1:0] rsv7_6;
    logic hi_flag;
    logic lo_flag;
    logic [1:0] rsv3_2;
    logic hi_enable;
    logic lo_enable;
  } mic_group_t;

  // One-cycle condition pulses from the internal sources.
  typedef struct packed {
    logic conv_done;
    logic serial_port;
    logic touch_sense;
    logic tick_a;
    logic tick_b;
    logic timer_period_match;
    logic timer_a_match;
    logic eeprom_done;
    logic low_supply;
  } mic_src_t;

  // Whole state of the block.
  typedef struct packed {
    mic_cmp_t cmp;
    mic_edge_t edge_sel;
    mic_ctrl_a_t ca;
    mic_ctrl_b_t cb;
    mic_ctrl_c_t cc;
    mic_group_t g0;
    mic_group_t g2;
    logic [2:0] sync1;
    logic [2:0] sync2;
    logic [1:0] pin_prev;
    logic irq_req;
    logic [3:0] irq_vec;
    logic wake_req;
    logic port_bit_read;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } mic_state_t;

endpackage

// *** hdl/mic_irq_ctrl.sv ***
// Interrupt request and enable logic with comparator output handling.
// Assumes an APB master on pclk, a CPU core on pclk that acknowledges
// the vector it services, and asynchronous pin and comparator inputs.
//
// The placing of the registers and the APB register port were decided locally.

`timescale 1ns/100ps

module mic_irq_ctrl (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [mic_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Asynchronous pins and comparator result.
  input wire logic ext_irq_pin_a,
  input wire logic ext_irq_pin_b,
  input wire logic cmp_analog_result,
  // Internal sources, one-cycle pulses on pclk.
  input wire mic_pkg::mic_src_t src_event,
  // CPU core side.
  input wire logic low_power_mode,
  input wire logic svc_ack,
  input wire logic [3:0] svc_vec,
  output logic irq_req,
  output logic [3:0] irq_vec,
  output logic wake_req,
  // Comparator control and shared port bit.
  input wire logic port_bit_in,
  output logic port_bit_read,
  output logic cmp_power_on,
  output logic cmp_hysteresis_on
);

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------

  // True when the selected edge type appears between two samples.
  function automatic logic edge_hit(
    input logic [1:0] sel,
    input logic prev,
    input logic cur
  );
    logic hit;
    hit = 1'b0;
    unique case (sel)
      mic_pkg::EDGE_OFF: hit = 1'b0;
      mic_pkg::EDGE_RISE: hit = cur & ~prev;
      mic_pkg::EDGE_FALL: hit = prev & ~cur;
      mic_pkg::EDGE_BOTH: hit = cur ^ prev;
    endcase
    return hit;
  endfunction

  // Lowest set request wins; ordering beyond that is the core's job.
  function automatic logic [3:0] pick_vec(
    input logic [mic_pkg::NUM_VEC-1:0] req
  );
    logic [3:0] v;
    v = mic_pkg::VEC_PIN_A;
    for (int i = mic_pkg::NUM_VEC - 1; i >= 0; i--) begin
      if (req[i]) begin
        v = 4'(i);
      end
    end
    return v;
  endfunction

  // True for a mapped register address.
  function automatic logic addr_ok(
    input logic [mic_pkg::ADDR_W-1:0] a
  );
    return (a == mic_pkg::OFF_CMP) || (a == mic_pkg::OFF_EDGE) ||
      (a == mic_pkg::OFF_CTRL_A) || (a == mic_pkg::OFF_CTRL_B) ||
      (a == mic_pkg::OFF_CTRL_C) || (a == mic_pkg::OFF_GROUP_ZERO) ||
      (a == mic_pkg::OFF_GROUP_TWO);
  endfunction

  // All request flags packed, used to spot rising flags for wake-up.
  function automatic logic [14:0] all_flags(
    input mic_pkg::mic_state_t x
  );
    return {x.ca.conv_done_flag, x.ca.pin_b_flag, x.ca.pin_a_flag,
      x.cb.serial_port_flag, x.cb.group_two_flag, x.cb.group_zero_flag,
      x.cc.comparator_flag, x.cc.touch_sense_flag, x.cc.tick_b_flag,
      x.cc.tick_a_flag, x.g0.hi_flag, x.g0.lo_flag, x.g2.hi_flag,
      x.g2.lo_flag, 1'b0};
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  mic_pkg::mic_state_t s_reg;
  mic_pkg::mic_state_t s_next;

  logic apb_done;
  logic wr;
  logic ack;
  logic pin_a_now;
  logic pin_b_now;
  logic cmp_now;
  logic new_result;
  logic [1:0] g0_old;
  logic [1:0] g2_old;
  logic [mic_pkg::NUM_VEC-1:0] req;

  // Write data seen through each register's own layout, so that no
  // field position is spelled out by hand; every register is one byte.
  localparam int REG_W = $bits(mic_pkg::mic_cmp_t);
  logic [REG_W-1:0] wbyte;
  mic_pkg::mic_cmp_t cmp_w;
  mic_pkg::mic_edge_t edge_w;

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------

  // Order inside: software write, service clears, then hardware sets,
  // so an event landing on a clear cycle is never lost.
  always_comb begin
    s_next = s_reg;
    apb_done = psel & penable & s_reg.pready;
    wr = apb_done & pwrite;
    ack = svc_ack;
    pin_a_now = s_reg.sync2[0];
    pin_b_now = s_reg.sync2[1];
    cmp_now = s_reg.sync2[2];
    req = '0;
    // Only the low byte of a bus word reaches a register.
    wbyte = pwdata[REG_W-1:0];
    cmp_w = wbyte;
    edge_w = wbyte;

    // Two-flop synchronisers; only the second stage is read below.
    s_next.sync1 = {cmp_analog_result, ext_irq_pin_b, ext_irq_pin_a};
    s_next.sync2 = s_reg.sync1;
    s_next.pin_prev = {pin_b_now, pin_a_now};

    // Register writes; reserved fields are never loaded.
    if (wr) begin
      unique case (paddr)
        mic_pkg::OFF_CMP: begin
          s_next.cmp.cmp_power_on = cmp_w.cmp_power_on;
          s_next.cmp.cmp_polarity_invert = cmp_w.cmp_polarity_invert;
          s_next.cmp.cmp_hysteresis_on = cmp_w.cmp_hysteresis_on;
        end
        mic_pkg::OFF_EDGE: begin
          s_next.edge_sel.pin_b_edge_sel = edge_w.pin_b_edge_sel;
          s_next.edge_sel.pin_a_edge_sel = edge_w.pin_a_edge_sel;
        end
        mic_pkg::OFF_CTRL_A: begin
          s_next.ca = wbyte;
          s_next.ca.rsv7 = 1'b0;
        end
        mic_pkg::OFF_CTRL_B: begin
          s_next.cb = wbyte;
          s_next.cb.rsv5 = 1'b0;
          s_next.cb.rsv1 = 1'b0;
        end
        mic_pkg::OFF_CTRL_C: begin
          s_next.cc = wbyte;
        end
        mic_pkg::OFF_GROUP_ZERO: begin
          s_next.g0 = wbyte;
          s_next.g0.rsv7_6 = '0;
          s_next.g0.rsv3_2 = '0;
        end
        mic_pkg::OFF_GROUP_TWO: begin
          s_next.g2 = wbyte;
          s_next.g2.rsv7_6 = '0;
          s_next.g2.rsv3_2 = '0;
        end
        default: begin
        end
      endcase
    end

    // Servicing clears the global enable, and the pin or group flag
    // of the serviced vector.
    if (ack) begin
      s_next.ca.global_irq_enable = 1'b0;
      if (svc_vec == mic_pkg::VEC_PIN_A) begin
        s_next.ca.pin_a_flag = 1'b0;
      end
      if (svc_vec == mic_pkg::VEC_PIN_B) begin
        s_next.ca.pin_b_flag = 1'b0;
      end
      if (svc_vec == mic_pkg::VEC_GROUP_ZERO) begin
        s_next.cb.group_zero_flag = 1'b0;
      end
      if (svc_vec == mic_pkg::VEC_GROUP_TWO) begin
        s_next.cb.group_two_flag = 1'b0;
      end
    end

    // Pin edges set the pin flags whatever the enables hold.
    if (edge_hit(s_reg.edge_sel.pin_a_edge_sel, s_reg.pin_prev[0],
        pin_a_now)) begin
      s_next.ca.pin_a_flag = 1'b1;
    end
    if (edge_hit(s_reg.edge_sel.pin_b_edge_sel, s_reg.pin_prev[1],
        pin_b_now)) begin
      s_next.ca.pin_b_flag = 1'b1;
    end

    // Internal source conditions.
    if (src_event.conv_done) begin
      s_next.ca.conv_done_flag = 1'b1;
    end
    if (src_event.serial_port) begin
      s_next.cb.serial_port_flag = 1'b1;
    end
    if (src_event.touch_sense) begin
      s_next.cc.touch_sense_flag = 1'b1;
    end
    if (src_event.tick_a) begin
      s_next.cc.tick_a_flag = 1'b1;
    end
    if (src_event.tick_b) begin
      s_next.cc.tick_b_flag = 1'b1;
    end
    if (src_event.timer_period_match) begin
      s_next.g0.lo_flag = 1'b1;
    end
    if (src_event.timer_a_match) begin
      s_next.g0.hi_flag = 1'b1;
    end
    if (src_event.low_supply) begin
      s_next.g2.lo_flag = 1'b1;
    end
    if (src_event.eeprom_done) begin
      s_next.g2.hi_flag = 1'b1;
    end

    // A secondary flag that rises, by hardware or software, sets its
    // group flag.
    g0_old = {s_reg.g0.hi_flag, s_reg.g0.lo_flag};
    g2_old = {s_reg.g2.hi_flag, s_reg.g2.lo_flag};
    if (|({s_next.g0.hi_flag, s_next.g0.lo_flag} & ~g0_old)) begin
      s_next.cb.group_zero_flag = 1'b1;
    end
    if (|({s_next.g2.hi_flag, s_next.g2.lo_flag} & ~g2_old)) begin
      s_next.cb.group_two_flag = 1'b1;
    end

    // The status bit follows the result, inverted when asked, and is
    // held while powered down so a power-off makes no spurious change.
    // Power is not touched by low-power mode.
    new_result = s_reg.cmp.cmp_result_bit;
    if (s_next.cmp.cmp_power_on) begin
      new_result = cmp_now ^ s_next.cmp.cmp_polarity_invert;
    end
    s_next.cmp.cmp_result_bit = new_result;
    // A change of the adjusted bit, not the raw input, sets the flag;
    // this also runs in sleep so the flag can wake the core.
    if (new_result != s_reg.cmp.cmp_result_bit) begin
      s_next.cc.comparator_flag = 1'b1;
    end

    // Wake on any flag rising while asleep; a flag preset before sleep
    // cannot rise, which is how software blocks a wake-up.
    s_next.wake_req = low_power_mode &
      (|(all_flags(s_next) & ~all_flags(s_reg)));

    // Primary requests in vector order; enable gates each.
    req[mic_pkg::VEC_PIN_A] = s_reg.ca.pin_a_flag & s_reg.ca.pin_a_enable;
    req[mic_pkg::VEC_PIN_B] = s_reg.ca.pin_b_flag & s_reg.ca.pin_b_enable;
    req[mic_pkg::VEC_CONV] = s_reg.ca.conv_done_flag &
      s_reg.ca.conv_done_enable;
    req[mic_pkg::VEC_GROUP_ZERO] = s_reg.cb.group_zero_flag &
      s_reg.cb.group_zero_enable;
    req[mic_pkg::VEC_GROUP_TWO] = s_reg.cb.group_two_flag &
      s_reg.cb.group_two_enable;
    req[mic_pkg::VEC_SERIAL] = s_reg.cb.serial_port_flag &
      s_reg.cb.serial_port_enable;
    req[mic_pkg::VEC_TICK_A] = s_reg.cc.tick_a_flag & s_reg.cc.tick_a_enable;
    req[mic_pkg::VEC_TICK_B] = s_reg.cc.tick_b_flag & s_reg.cc.tick_b_enable;
    req[mic_pkg::VEC_TOUCH] = s_reg.cc.touch_sense_flag &
      s_reg.cc.touch_sense_enable;
    req[mic_pkg::VEC_CMP] = s_reg.cc.comparator_flag &
      s_reg.cc.comparator_enable;

    // Global enable gates irq_req, not irq_vec or wake_req; a request drops the cycle after
    // the acknowledge because ack masks it, then stays off as the global enable is cleared.
    s_next.irq_req = s_reg.ca.global_irq_enable & (|req) & ~ack;
    s_next.irq_vec = pick_vec(req);

    // The shared pin reads zero while the comparator owns it.
    s_next.port_bit_read = port_bit_in & ~s_reg.cmp.cmp_power_on;

    // APB: ready comes one cycle into the access phase.
    s_next.pready = psel & penable & ~s_reg.pready;
    s_next.pslverr = psel & penable & ~s_reg.pready & ~addr_ok(paddr);
    s_next.prdata = '0;
    if (psel & penable & ~s_reg.pready & ~pwrite) begin
      unique case (paddr)
        mic_pkg::OFF_CMP: s_next.prdata[REG_W-1:0] = s_reg.cmp;
        mic_pkg::OFF_EDGE: s_next.prdata[REG_W-1:0] = s_reg.edge_sel;
        mic_pkg::OFF_CTRL_A: s_next.prdata[REG_W-1:0] = s_reg.ca;
        mic_pkg::OFF_CTRL_B: s_next.prdata[REG_W-1:0] = s_reg.cb;
        mic_pkg::OFF_CTRL_C: s_next.prdata[REG_W-1:0] = s_reg.cc;
        mic_pkg::OFF_GROUP_ZERO: s_next.prdata[REG_W-1:0] = s_reg.g0;
        mic_pkg::OFF_GROUP_TWO: s_next.prdata[REG_W-1:0] = s_reg.g2;
        default: s_next.prdata = '0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------

  // Everything resets to constants; comparator hysteresis starts on.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= '0;
      s_reg.cmp <= mic_pkg::CMP_RST;
      s_reg.edge_sel <= mic_pkg::REG_RST;
      s_reg.ca <= mic_pkg::REG_RST;
      s_reg.cb <= mic_pkg::REG_RST;
      s_reg.cc <= mic_pkg::REG_RST;
      s_reg.g0 <= mic_pkg::REG_RST;
      s_reg.g2 <= mic_pkg::REG_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, all straight from the state register
  // ----------------------------------------------------------------
  assign prdata = s_reg.prdata;
  assign pready = s_reg.pready;
  assign pslverr = s_reg.pslverr;
  assign irq_req = s_reg.irq_req;
  assign irq_vec = s_reg.irq_vec;
  assign wake_req = s_reg.wake_req;
  assign port_bit_read = s_reg.port_bit_read;
  assign cmp_power_on = s_reg.cmp.cmp_power_on;
  assign cmp_hysteresis_on = s_reg.cmp.cmp_hysteresis_on;

endmodule

// *** test/mic_irq_ctrl_chk.sv ***
// Port-level assertions of the interrupt request block.
// Assumes it is bound to mic_irq_ctrl and sees only its ports.
`timescale 1ns/100ps
// ------------------------------
// Checker
// ------------------------------
module mic_irq_ctrl_chk (
  // Clock, reset and bus.
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [mic_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Core and comparator side.
  input wire logic low_power_mode,
  input wire logic svc_ack,
  input wire logic irq_req,
  input wire logic wake_req,
  input wire logic port_bit_in,
  input wire logic port_bit_read,
  input wire logic cmp_power_on,
  input wire logic cmp_hysteresis_on
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // A completed write to the comparator register.
  logic wr_cmp;
  assign wr_cmp = psel && penable && pready && pwrite && paddr == mic_pkg::OFF_CMP;

  bus_wait_state_a: assert property (psel && !penable |-> ##2 pready ##1 !pready)
    else $error("bus answer not on the second edge");
  upper_zero_a: assert property (pready |-> prdata[31:8] == '0)
    else $error("read data upper bits not zero");
  unmapped_err_a: assert property (psel && penable && pready && (paddr > 8'h18 || paddr[1:0] != 2'h0)
    |-> pslverr && prdata == '0)
    else $error("unmapped access not refused");
  port_masked_a: assert property (cmp_power_on && $past(cmp_power_on) |-> !port_bit_read)
    else $error("port bit visible while comparator on");
  port_pass_a: assert property ($past(presetn) && !cmp_power_on && !$past(cmp_power_on)
    |-> port_bit_read == $past(port_bit_in))
    else $error("port bit not passed while comparator off");
  cmp_ctrl_write_a: assert property (wr_cmp |=> cmp_hysteresis_on == $past(pwdata[0])
    && cmp_power_on == $past(pwdata[6]))
    else $error("comparator control bits not taken");
  sleep_power_a: assert property (cmp_power_on && low_power_mode && !wr_cmp |=> cmp_power_on)
    else $error("comparator dropped in sleep");
  wake_in_sleep_a: assert property (wake_req |-> $past(low_power_mode))
    else $error("wake pulse outside sleep");
  svc_drop_a: assert property (svc_ack && irq_req |=> !irq_req)
    else $error("request kept after service");
endmodule

bind mic_irq_ctrl mic_irq_ctrl_chk chk_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .low_power_mode(low_power_mode), .svc_ack(svc_ack), .irq_req(irq_req), .wake_req(wake_req),
  .port_bit_in(port_bit_in), .port_bit_read(port_bit_read), .cmp_power_on(cmp_power_on),
  .cmp_hysteresis_on(cmp_hysteresis_on));

// *** test/mic_cpu_model.sv ***
// Behavioural core that services vectored requests and sleeps.
// Assumes the block's outputs are registers on pclk.
`timescale 1ns/100ps
// ------------------------------
// Core model
// ------------------------------
module mic_cpu_model (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Block side.
  input wire logic irq_req,
  input wire logic [3:0] irq_vec,
  input wire logic wake_req,
  output logic svc_ack,
  output logic [3:0] svc_vec,
  output logic low_power_mode,
  // Bench controls.
  input wire logic accept,
  input wire logic sleep_cmd,
  input wire logic [3:0] ack_wait,
  output logic [3:0] last_vec
);
  // One action per edge; the vector lines are scrambled outside a pulse so nothing reads stale data.
  initial begin
    svc_ack = 1'b0;
    svc_vec = 4'h0;
    low_power_mode = 1'b0;
    last_vec = 4'hF;
    forever begin
      @(posedge pclk);
      if (!presetn || svc_ack) begin
        svc_ack <= 1'b0;
        svc_vec <= ~svc_vec;
        if (!presetn) low_power_mode <= 1'b0;
      end else if (low_power_mode) begin
        if (wake_req) low_power_mode <= 1'b0;
      end else if (sleep_cmd) begin
        low_power_mode <= 1'b1;
      end else if (irq_req && accept) begin
        repeat (ack_wait) @(posedge pclk);
        svc_ack <= 1'b1;
        svc_vec <= irq_vec;
        last_vec <= irq_vec;
      end
    end
  end
endmodule

// *** test/mic_irq_ctrl_tb_top.sv ***
// Self-checking bench of the interrupt request block.
// Assumes the block, its checker and the core model compile before it.
`timescale 1ns/100ps
// ------------------------------
// Bench
// ------------------------------
module mic_irq_ctrl_tb_top;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic pin_a, pin_b, cmp_res, port_in, port_rd, pwr, hys, irq, wake, lpm, ack, accept, sleep_cmd;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] ivec, svec, last_vec, ack_wait;
  logic [1:0] ca, cb;
  logic [7:0] offs [7];
  mic_pkg::mic_src_t src;
  int bad_count, tests_run, cyc;

  mic_irq_ctrl DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_irq_pin_a(pin_a), .ext_irq_pin_b(pin_b), .cmp_analog_result(cmp_res), .src_event(src),
    .low_power_mode(lpm), .svc_ack(ack), .svc_vec(svec), .irq_req(irq), .irq_vec(ivec), .wake_req(wake),
    .port_bit_in(port_in), .port_bit_read(port_rd), .cmp_power_on(pwr), .cmp_hysteresis_on(hys));
  mic_cpu_model core (.pclk(pclk), .presetn(presetn), .irq_req(irq), .irq_vec(ivec), .wake_req(wake),
    .svc_ack(ack), .svc_vec(svec), .low_power_mode(lpm), .accept(accept), .sleep_cmd(sleep_cmd),
    .ack_wait(ack_wait), .last_vec(last_vec));

  // Free-running clock of 10 ns.
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // Hang guard; the whole run needs well under a thousand cycles.
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish;
    if (bad_count == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // One transfer; an idle edge follows so the select is never reassigned in one step.
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    chk("pready", 32'h1, {31'h0, pready});
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    apb(a, 1'b0, 32'h0);
    chk($sformatf("register %h", a), exp, rd);
  endtask

  // Clears groups before the primary flags, so no group rise refills them.
  task automatic clr_all;
    for (int i = 6; i > 0; i--) apb(offs[i], 1'b1, 32'h0);
  endtask

  // Main sequence.
  initial begin
    offs = '{mic_pkg::OFF_CMP, mic_pkg::OFF_EDGE, mic_pkg::OFF_CTRL_A, mic_pkg::OFF_CTRL_B,
             mic_pkg::OFF_CTRL_C, mic_pkg::OFF_GROUP_ZERO, mic_pkg::OFF_GROUP_TWO};
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h0; pwdata = 32'h0;
    pin_a = 1'b0; pin_b = 1'b0; cmp_res = 1'b0; port_in = 1'b1; src = '0;
    accept = 1'b0; sleep_cmd = 1'b0; ack_wait = 4'h0; bad_count = 0; tests_run = 0; cyc = 0;
    tick(20);
    presetn <= 1'b1;
    @(posedge pclk);
    rchk(offs[0], {24'h0, mic_pkg::CMP_RST});
    for (int i = 1; i < 7; i++) rchk(offs[i], 32'h0);
    chk("port read", 32'h1, {31'h0, port_rd});
    // All ones, except the global enable, then the reserved bits read zero.
    apb(offs[1], 1'b1, 32'hFF);
    apb(offs[2], 1'b1, 32'hFE);
    for (int i = 3; i < 7; i++) apb(offs[i], 1'b1, 32'hFF);
    rchk(offs[1], 32'h0F);
    rchk(offs[2], 32'h7E);
    rchk(offs[3], 32'hDD);
    rchk(offs[5], 32'h33);
    chk("irq blocked", 32'h0, {31'h0, irq});
    apb(offs[2], 1'b1, 32'hFF);
    tick(2);
    chk("irq", 32'h1, {31'h0, irq});
    chk("irq vec", {28'h0, mic_pkg::VEC_PIN_A}, {28'h0, ivec});
    accept <= 1'b1;
    ack_wait <= 4'h5;
    tick(12);
    accept <= 1'b0;
    chk("served vec", {28'h0, mic_pkg::VEC_PIN_A}, {28'h0, last_vec});
    rchk(offs[2], 32'h6E);
    clr_all();
    for (int i = 1; i < 7; i++) rchk(offs[i], 32'h0);
    apb(8'h1C, 1'b1, 32'hFF);
    chk("write err", 32'h1, {31'h0, err});
    apb(8'h1C, 1'b0, 32'h0);
    chk("read err", 32'h1, {31'h0, err});
    chk("read data", 32'h0, rd);
    // Every edge code, pin b taking the opposite code; enables stay off.
    for (int c = 0; c < 4; c++) begin
      ca = 2'(c);
      cb = 2'(3 - c);
      apb(offs[1], 1'b1, {28'h0, cb, ca});
      pin_a <= 1'b1;
      pin_b <= 1'b1;
      tick(8);
      rchk(offs[2], {26'h0, cb[0], ca[0], 4'h0});
      apb(offs[2], 1'b1, 32'h0);
      pin_a <= 1'b0;
      pin_b <= 1'b0;
      tick(8);
      rchk(offs[2], {26'h0, cb[1], ca[1], 4'h0});
      apb(offs[2], 1'b1, 32'h0);
    end
    // Each internal source pulses once.
    for (int i = 0; i < 9; i++) begin
      src <= mic_pkg::mic_src_t'(9'h1 << i);
      @(posedge pclk);
      src <= '0;
      @(posedge pclk);
    end
    rchk(offs[2], 32'h40);
    rchk(offs[3], 32'hD0);
    rchk(offs[4], 32'h70);
    rchk(offs[5], 32'h30);
    rchk(offs[6], 32'h30);
    // Group two served: its group flag clears, its secondary flags stay.
    apb(offs[3], 1'b1, 32'hD4);
    apb(offs[2], 1'b1, 32'h41);
    accept <= 1'b1;
    ack_wait <= 4'h0;
    tick(8);
    accept <= 1'b0;
    chk("served vec", {28'h0, mic_pkg::VEC_GROUP_TWO}, {28'h0, last_vec});
    rchk(offs[3], 32'h94);
    rchk(offs[6], 32'h30);
    rchk(offs[2], 32'h40);
    clr_all();
    // Comparator on, polarity straight, then inverted.
    apb(offs[0], 1'b1, 32'h40);
    tick(2);
    chk("power", 32'h1, {31'h0, pwr});
    chk("hysteresis", 32'h0, {31'h0, hys});
    chk("port masked", 32'h0, {31'h0, port_rd});
    cmp_res <= 1'b1;
    tick(8);
    rchk(offs[0], 32'h50);
    rchk(offs[4], 32'h80);
    apb(offs[0], 1'b1, 32'h60);
    tick(8);
    rchk(offs[0], 32'h60);
    clr_all();
    apb(offs[4], 1'b1, 32'h08);
    apb(offs[2], 1'b1, 32'h01);
    accept <= 1'b1;
    ack_wait <= 4'h0;
    cmp_res <= 1'b0;
    tick(12);
    accept <= 1'b0;
    chk("served vec", {28'h0, mic_pkg::VEC_CMP}, {28'h0, last_vec});
    clr_all();
    // Sleep; a comparator change wakes the core.
    sleep_cmd <= 1'b1;
    @(posedge pclk);
    sleep_cmd <= 1'b0;
    tick(2);
    chk("asleep", 32'h1, {31'h0, lpm});
    cmp_res <= 1'b1;
    tick(8);
    chk("woken", 32'h0, {31'h0, lpm});
    // Flag preset before sleep keeps the core asleep.
    apb(offs[4], 1'b1, 32'h80);
    sleep_cmd <= 1'b1;
    @(posedge pclk);
    sleep_cmd <= 1'b0;
    cmp_res <= 1'b0;
    tick(10);
    chk("still asleep", 32'h1, {31'h0, lpm});
    apb(offs[4], 1'b1, 32'h0);
    apb(offs[4], 1'b1, 32'h80);
    tick(3);
    chk("woken by write", 32'h0, {31'h0, lpm});
    apb(offs[0], 1'b1, 32'h01);
    tick(2);
    chk("power off", 32'h0, {31'h0, pwr});
    chk("hysteresis on", 32'h1, {31'h0, hys});
    chk("port passed", 32'h1, {31'h0, port_rd});
    port_in <= 1'b0;
    tick(2);
    chk("port low passed", 32'h0, {31'h0, port_rd});
    tally_and_finish();
  end
endmodule
